// ==== hw/dtc_timer.v ====
/*
  Two 16-bit timer/counters with four modes, APB register slave.
  Assumes count and gate inputs are synchronous to sys_clk_i, and a
  32-bit APB master on the same clock.
*/
// How it works
// - Two-bit field picks one of four modes
// - Mode 0 stopped: low write loads reload and count
// - Mode 0 counts up, overflow reloads and flags
// - Mode 0 running: writes change reload only
// - Mode 0 high byte buffered until low-byte write
// - Later high byte waits for next low write
// - Mode 1 plain 16-bit counter sets flag
// - Counter select counts external falling edges
// - Gate needs run and gate pin high
// - Setting run keeps the held count
// - Mode 2 low counts, high reloads
// - Prescale picks full or divide-by-12 clock
// - Toggle enable flips pin on overflow
// - Split low byte uses timer 0 controls
// - Split high byte uses timer 1 run/flag
// - Timer 1 runs but never flags in split
// - Timer 1 in split: clock only, no gate
// - Timer 1 stopped by its mode 3
// - Control register flags and run bits
// - Mode register gate, select, mode per timer
// - Second control: toggle and prescale bits
`include "dtc_map.vh"
`timescale 1ns/10ps
`default_nettype none

module dtc_timer (
  // Clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Pins
  input wire [1:0] count_pin_i,
  input wire [1:0] gate_input_pin_i,
  output reg [1:0] timer_out_o,
  output reg [1:0] overflow_flag_o
);

  reg [7:0] ctrl_q;
  reg [7:0] ctrl2_q;
  reg [7:0] mode_q;
  reg [7:0] tl_q [0:1];
  reg [7:0] th_q [0:1];
  reg [7:0] rl_lo_q [0:1];
  reg [7:0] rl_hi_q [0:1];
  reg [7:0] hbuf_q [0:1];
  reg [1:0] cnt_s1_q, cnt_s2_q, cnt_s3_q;
  reg [1:0] gate_s1_q, gate_s2_q;
  reg [3:0] pre_q;
  reg [1:0] ovf_tog;
  wire pre_tick = (pre_q == `DTC_PRESCALE_DIV);

  // One wait state; pready only on the second access-phase cycle
  wire acc = psel_i & penable_i & ~pready_o;
  wire wr = acc & pwrite_i & pstrb_i[0];
  wire hit = (paddr_i == `DTC_OFS_CTRL) | (paddr_i == `DTC_OFS_CTRL2) | (paddr_i == `DTC_OFS_MODE) |
             (paddr_i == `DTC_OFS_T0_LOW) | (paddr_i == `DTC_OFS_T0_HIGH) |
             (paddr_i == `DTC_OFS_T1_LOW) | (paddr_i == `DTC_OFS_T1_HIGH);
  wire split = (mode_q[1:0] == `DTC_M_SPLIT);

  // Flag set events from both timers
  reg [1:0] flag_set;

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= acc;
      pslverr_o <= acc & ~hit;
      prdata_o <= 32'h0000_0000;
      if (acc & ~pwrite_i) begin
        case (paddr_i)
          `DTC_OFS_CTRL: prdata_o <= {24'h00_0000, ctrl_q[7:4], 4'h0};
          `DTC_OFS_CTRL2: prdata_o <= {24'h00_0000, ctrl2_q};
          `DTC_OFS_MODE: prdata_o <= {24'h00_0000, mode_q};
          `DTC_OFS_T0_LOW: prdata_o <= {24'h00_0000, tl_q[0]};
          `DTC_OFS_T0_HIGH: prdata_o <= {24'h00_0000, th_q[0]};
          `DTC_OFS_T1_LOW: prdata_o <= {24'h00_0000, tl_q[1]};
          `DTC_OFS_T1_HIGH: prdata_o <= {24'h00_0000, th_q[1]};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Synchronisers; stage 1 feeds only stage 2
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_s1_q <= 2'b00;
      cnt_s2_q <= 2'b00;
      cnt_s3_q <= 2'b00;
      gate_s1_q <= 2'b00;
      gate_s2_q <= 2'b00;
      pre_q <= 4'h0;
    end else begin
      cnt_s1_q <= count_pin_i;
      cnt_s2_q <= cnt_s1_q;
      cnt_s3_q <= cnt_s2_q;
      gate_s1_q <= gate_input_pin_i;
      gate_s2_q <= gate_s1_q;
      pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
    end
  end

  // Per-timer count enables
  reg [1:0] inc;
  reg inc_hi0;
  integer k;
  always @* begin
    inc_hi0 = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      if (mode_q[4*k+`DTC_MODE_CNT] && !(k == 1 && split)) begin
        inc[k] = cnt_s3_q[k] & ~cnt_s2_q[k];
      end else begin
        inc[k] = ctrl2_q[4*k] | pre_tick;
      end
      if (k == 1 && split) begin
        inc[k] = inc[k] & (mode_q[5:4] != `DTC_M_SPLIT);
      end else begin
        inc[k] = inc[k] & ctrl_q[`DTC_CTRL_T0_RUN + 2*k] &
                 (~mode_q[4*k+`DTC_MODE_GATE] | gate_s2_q[k]);
        if (k == 1 && mode_q[5:4] == `DTC_M_SPLIT) begin
          inc[k] = 1'b0;
        end
      end
    end
    inc_hi0 = split & ctrl_q[`DTC_CTRL_T1_RUN] & (ctrl2_q[0] | pre_tick);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tmr
      wire [1:0] md = mode_q[4*g+1:4*g];
      wire wlo = wr & (paddr_i == (g ? `DTC_OFS_T1_LOW : `DTC_OFS_T0_LOW));
      wire whi = wr & (paddr_i == (g ? `DTC_OFS_T1_HIGH : `DTC_OFS_T0_HIGH));
      wire run = (g == 1 && split) ? (md != `DTC_M_SPLIT) : ctrl_q[`DTC_CTRL_T0_RUN + 2*g];
      wire [15:0] cnt = {th_q[g], tl_q[g]};
      wire hi_split = (g == 0) && split;
      reg ovf;
      always @* begin
        case (md)
          `DTC_M_RELOAD16, `DTC_M_PLAIN16: ovf = inc[g] & (cnt == 16'hFFFF);
          `DTC_M_RELOAD8: ovf = inc[g] & (tl_q[g] == 8'hFF);
          `DTC_M_SPLIT: ovf = inc[g] & (g == 0) & (tl_q[g] == 8'hFF);
          default: ovf = 1'b0;
        endcase
        ovf_tog[g] = ovf | (hi_split & inc_hi0 & (th_q[0] == 8'hFF));
      end
      always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          tl_q[g] <= `DTC_RESET_BYTE;
          th_q[g] <= `DTC_RESET_BYTE;
          rl_lo_q[g] <= `DTC_RESET_BYTE;
          rl_hi_q[g] <= `DTC_RESET_BYTE;
          hbuf_q[g] <= `DTC_RESET_BYTE;
          timer_out_o[g] <= 1'b0;
        end else begin
          if (ovf_tog[g] & ctrl2_q[4*g+1]) begin
            timer_out_o[g] <= ~timer_out_o[g];
          end
          if (md == `DTC_M_RELOAD16) begin
            if (ovf) begin
              tl_q[g] <= rl_lo_q[g];
              th_q[g] <= rl_hi_q[g];
            end else if (inc[g]) begin
              {th_q[g], tl_q[g]} <= cnt + 16'h0001;
            end
            if (whi) begin
              hbuf_q[g] <= pwdata_i[7:0];
            end
            if (wlo) begin
              rl_lo_q[g] <= pwdata_i[7:0];
              rl_hi_q[g] <= hbuf_q[g];
              if (!run) begin
                tl_q[g] <= pwdata_i[7:0];
                th_q[g] <= hbuf_q[g];
              end
            end
          end else begin
            if (wlo) begin
              tl_q[g] <= pwdata_i[7:0];
            end else if (ovf && md == `DTC_M_RELOAD8) begin
              tl_q[g] <= th_q[g];
            end else if (inc[g] && md == `DTC_M_PLAIN16) begin
              tl_q[g] <= tl_q[g] + 8'h01;
            end else if (inc[g]) begin
              tl_q[g] <= tl_q[g] + 8'h01;
            end
            if (whi) begin
              th_q[g] <= pwdata_i[7:0];
            end else if (inc[g] && md == `DTC_M_PLAIN16 && tl_q[g] == 8'hFF) begin
              th_q[g] <= th_q[g] + 8'h01;
            end else if (hi_split && inc_hi0) begin
              th_q[g] <= th_q[g] + 8'h01;
            end
          end
        end
      end
      always @* begin
        if (g == 1) begin
          flag_set[g] = split ? (inc_hi0 & (th_q[0] == 8'hFF)) : ovf;
        end else begin
          flag_set[g] = ovf;
        end
      end
    end
  endgenerate

  // Control registers; hardware set beats software clear
  wire wctl = wr & (paddr_i == `DTC_OFS_CTRL);
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= 8'h00;
      ctrl2_q <= 8'h00;
      mode_q <= 8'h00;
      overflow_flag_o <= 2'b00;
    end else begin
      if (wctl) begin
        ctrl_q <= {pwdata_i[7:4], 4'h0};
      end
      if (flag_set[0]) begin
        ctrl_q[`DTC_CTRL_T0_FLAG] <= 1'b1;
      end
      if (flag_set[1]) begin
        ctrl_q[`DTC_CTRL_T1_FLAG] <= 1'b1;
      end
      overflow_flag_o[0] <= flag_set[0] | (wctl ? pwdata_i[5] : ctrl_q[5]);
      overflow_flag_o[1] <= flag_set[1] | (wctl ? pwdata_i[7] : ctrl_q[7]);
      if (wr && paddr_i == `DTC_OFS_CTRL2) begin
        ctrl2_q <= pwdata_i[7:0] & `DTC_CTRL2_MASK;
      end
      if (wr && paddr_i == `DTC_OFS_MODE) begin
        mode_q <= pwdata_i[7:0];
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/dtc_map.vh ====
/*
  Register map and constants of the dual timer/counter.
  Assumes inclusion by the timer design file only.
*/
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

`define DTC_ADDR_W 12
`define DTC_OFS_CTRL 12'h000
`define DTC_OFS_CTRL2 12'h004
`define DTC_OFS_MODE 12'h008
`define DTC_OFS_T0_LOW 12'h00C
`define DTC_OFS_T0_HIGH 12'h010
`define DTC_OFS_T1_LOW 12'h014
`define DTC_OFS_T1_HIGH 12'h018

`define DTC_CTRL_T1_FLAG 7
`define DTC_CTRL_T1_RUN 6
`define DTC_CTRL_T0_FLAG 5
`define DTC_CTRL_T0_RUN 4
`define DTC_CTRL2_T1_TOG 5
`define DTC_CTRL2_T1_FULL 4
`define DTC_CTRL2_T0_TOG 1
`define DTC_CTRL2_T0_FULL 0
`define DTC_CTRL2_MASK 8'h33
`define DTC_MODE_GATE 3
`define DTC_MODE_CNT 2

`define DTC_M_RELOAD16 2'b00
`define DTC_M_PLAIN16 2'b01
`define DTC_M_RELOAD8 2'b10
`define DTC_M_SPLIT 2'b11

`define DTC_PRESCALE_DIV 4'hB
`define DTC_RESET_BYTE 8'h00

`endif

// ==== bench/dtc_chk.sv ====
/* Checker of APB answer timing and read data shape.
   Bound to dtc_timer from the bench top. */
`timescale 1ns/10ps
`default_nettype none
module dtc_chk (
  // Clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Pins
  input wire [1:0] timer_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire rd = pready_o && !pwrite_i;
  one_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no answer");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("long pready");
  rdy_cause_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("stray pready");
  err_with_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("stray error");
  data_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("data outside answer");
  byte_wide_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("wide data");
  ctrl_low_a: assert property (rd && paddr_i == 12'h000 |-> prdata_o[3:0] == 4'h0)
    else $error("ctrl low bits");
  ctrl2_resv_a: assert property (rd && paddr_i == 12'h004 |-> (prdata_o[7:0] & 8'hCC) == 8'h0)
    else $error("ctrl2 reserved bits");
  unmapped_a: assert property (pready_o && paddr_i > 12'h018 |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access");
  cover property (pslverr_o);
  cover property ($rose(timer_out_o[0]));
  cover property (rd && paddr_i == 12'h004);
endmodule
`default_nettype wire

// ==== bench/dtc_pins.sv ====
/* Pin model: count pulses and gate levels for both timers.
   Assumes one-cycle pulse requests at least two cycles apart. */
`timescale 1ns/10ps
`default_nettype none
module dtc_pins (
  // Clock
  input wire sys_clk_i,
  // Bench requests
  input wire [1:0] pulse_i,
  input wire [1:0] gate_i,
  // Pins
  output reg [1:0] count_pin_o = 2'h3,
  output reg [1:0] gate_pin_o = 2'h0
);
  // Idle high, so only a request makes a falling edge
  always @(posedge sys_clk_i) begin
    count_pin_o <= ~pulse_i;
    gate_pin_o <= gate_i;
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
/* Bench: APB register and counting tests of dtc_timer.
   Assumes dtc_chk and dtc_pins compiled before. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0] pulse = 2'h0, gate = 2'h0;
  logic [16:0] lf = 17'h1_6B42;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] cpin, gpin, tout, oflag;
  int n_mismatch = 0, n_tests = 0, k, n;
  dtc_timer i_dtc_timer (.sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .count_pin_i(cpin), .gate_input_pin_i(gpin),
    .timer_out_o(tout), .overflow_flag_o(oflag));
  dtc_pins i_dtc_pins (.sys_clk_i(sys_clk), .pulse_i(pulse), .gate_i(gate), .count_pin_o(cpin),
    .gate_pin_o(gpin));
  always #5 sys_clk = ~sys_clk;
  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic give_verdict;
    $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] reg %h exp %h got %h", paddr, e, g);
    end
  endtask
  // Bounded waits: a hang counts as a mismatch
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic [11:0] ra, input logic [31:0] e);
    apb(1, a, d);
    apb(0, ra, 32'h0);
    chk(e, rd);
  endtask
  task automatic wait_flag(input int b);
    for (k = 0; k < 2000 && oflag[b] !== 1'b1; k++) @(posedge sys_clk);
    if (k == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // Sync delay is three clocks, so pulses are spaced by four
  task automatic pulses(input int c);
    repeat (6) @(posedge sys_clk);
    repeat (c) begin
      pulse <= 2'h1;
      @(posedge sys_clk);
      pulse <= 2'h0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1;
    for (int a = 0; a < 32; a += 4) begin
      apb(0, a[11:0], 32'h0);
      chk(32'h0, rd);
      chk({31'h0, a == 28}, {31'h0, er});
    end
    for (int m = 0; m < 4; m++) begin
      lf = step(lf);
      wc(12'h008, {24'h0, lf[7:6], m[1:0], lf[5:4], m[1:0]}, 12'h008, {24'h0, lf[7:6], m[1:0], lf[5:4], m[1:0]});
    end
    wc(12'h004, 32'hFF, 12'h004, 32'h33);
    wc(12'h000, 32'h0F, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h0);
    wc(12'h010, 32'h05, 12'h010, 32'h0);
    wc(12'h00C, 32'h08, 12'h010, 32'h05);
    wc(12'h010, 32'h06, 12'h010, 32'h05);
    wc(12'h00C, 32'h00, 12'h010, 32'h06);
    wc(12'h010, 32'hFF, 12'h00C, 32'h00);
    wc(12'h00C, 32'h00, 12'h010, 32'hFF);
    wc(12'h000, 32'h10, 12'h010, 32'hFF);
    wc(12'h010, 32'h12, 12'h010, 32'hFF);
    wc(12'h00C, 32'h34, 12'h010, 32'hFF);
    wait_flag(0);
    chk(32'h1, {30'h0, tout});
    apb(0, 12'h010, 32'h0);
    chk(32'h12, rd);
    apb(0, 12'h000, 32'h0);
    chk(32'h30, rd);
    wc(12'h000, 32'h10, 12'h000, 32'h10);
    wc(12'h008, 32'h20, 12'h000, 32'h10);
    wc(12'h018, 32'hF0, 12'h018, 32'hF0);
    wc(12'h014, 32'hFE, 12'h014, 32'hFE);
    apb(1, 12'h000, 32'h40);
    wait_flag(1);
    wc(12'h000, 32'h0, 12'h018, 32'hF0);
    apb(1, 12'h008, 32'h0D);
    apb(1, 12'h00C, 32'h0);
    wc(12'h000, 32'h10, 12'h00C, 32'h0);
    lf = step(lf);
    n = lf[2:0] + 1;
    pulses(n);
    apb(0, 12'h00C, 32'h0);
    chk(32'h0, rd);
    gate <= 2'h1;
    pulses(n);
    apb(0, 12'h00C, 32'h0);
    chk(n, rd);
    apb(1, 12'h008, 32'h10);
    apb(1, 12'h014, 32'h0);
    apb(1, 12'h004, 32'h03);
    apb(1, 12'h000, 32'h40);
    repeat (120) @(posedge sys_clk);
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h014, 32'h0);
    chk(32'h1, {31'h0, rd >= 9 && rd <= 11});
    apb(1, 12'h008, 32'h03);
    apb(1, 12'h004, 32'h33);
    apb(1, 12'h010, 32'hFE);
    apb(1, 12'h000, 32'h40);
    wait_flag(1);
    chk(32'h0, {31'h0, oflag[0]});
    give_verdict();
  end
endmodule
bind dtc_timer dtc_chk i_dtc_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_out_o(timer_out_o));
`default_nettype wire
